/* File: rtl/sds_pkg.sv */
// Package for the SPI diagnostic status slave: constants, types, encodings.
// Assumes one system clock at 250 MHz and a separate SPI serial clock domain.
package sds_pkg;

  localparam int SYS_CLK_MHZ = 250;
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int SETUP_TIME_US = 10;
  localparam int SETUP_CYCLES = SETUP_TIME_US * SYS_CLK_MHZ;

  // Address byte layout
  localparam int ADDR_OP_BIT = 7;
  localparam int ADDR_HI_BIT = 6;
  localparam int ADDR_LO_BIT = 2;
  localparam int ADDR_LAST_ADDRESS_TOKEN_BIT = 1;
  localparam int ADDR_ONE_BIT = 0;

  // Global status byte layout
  localparam int GSB_PROTO = 7;
  localparam int GSB_LOAD = 6;
  localparam int GSB_UNDER = 5;
  localparam int GSB_OVER = 4;
  localparam int GSB_NRESET = 3;
  localparam int GSB_TSD = 2;
  localparam int GSB_TPW = 1;

  // Register addresses
  localparam logic [4:0] REG_GLOBAL_STATUS = 5'h00;
  localparam logic [4:0] REG_OPEN_LOAD_HS = 5'h01;
  localparam logic [4:0] REG_OPEN_LOAD_LS = 5'h02;
  localparam logic [4:0] REG_LED_OL_CONFIG = 5'h03;
  localparam logic [7:0] LED_OL_CONFIG_RESET = 8'h00;

  typedef enum logic [2:0] {
    SDS_IDLE  = 3'b001,
    SDS_FRAME = 3'b010,
    SDS_APPLY = 3'b100
  } sds_state_t;

  typedef struct packed {
    logic       valid_len;
    logic       pol_err;
    logic [7:0] addr;
    logic [7:0] data;
  } sds_frame_t;

  typedef struct packed {
    logic under;
    logic over;
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
  } sds_supply_t;

endpackage

/* File: rtl/sds_spi_slave.sv */
// SPI slave with global status reporting, open-load latching and supply flags.
// Assumes csn/sclk/sdi come from pins; sclk clocks the shift logic directly.
`timescale 1ns/1ps

// Behaviour
// - Undervoltage: stages off, flag latched, auto-recover
// - Overvoltage: stages off, flag latched, auto-recover
// - Logic supply low resets logic, outputs off
// - Reset reported as negated reset bit zero
// - Open load latches bit and load error
// - Free-wheeling stages blank open-load detection
// - First two high sides use selectable config; code only outputs the config, detection ignores it
// - 16-bit frames, mode 0/1, sample falling
// - Chip select high: interpret word, release output
// - Addressed register returned in same frame
// - Bytewise access, flags cleared only by master
// - Ignore frames until setup time after enable
// - Before first rising edge output flag OR input
// - First eight clocks shift global status byte
// - Global error is OR of status bits, with the negated reset bit inverted
// - Load error is OR of failure bits
// - Negated reset bit reads zero after reset
// - Protocol error bit 7, reported next frame
// - Bad clock count flags protocol error
// - Bad address, LSB or token flags error
// - Clock high at chip select edges errors
// - Address byte: op, address, token, one
// - Op set writes or clears, else read
module sds_spi_slave #(
  parameter int N_OUT = 8,
  parameter int SETUP_CNT = sds_pkg::SETUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic logic_supply_ok,
  input wire logic enable_pin,
  input wire logic csn,
  input wire logic sclk,
  input wire logic sdi,
  input wire sds_pkg::sds_supply_t supply_in,
  input wire logic [N_OUT-1:0] hs_open_load_det,
  input wire logic [N_OUT-1:0] ls_open_load_det,
  input wire logic [N_OUT-1:0] hs_overcurrent,
  input wire logic [N_OUT-1:0] ls_overcurrent,
  input wire logic [N_OUT-1:0] freewheel_active,
  output logic stages_enable,
  output logic outputs_hiz,
  output logic [7:0] led_open_load_config,
  output logic global_status_byte_o,
  output logic sdo,
  output logic sdo_oe
);
  import sds_pkg::*;

  // ----------------------------------------------------------------
  // Reset from external reset and logic supply
  // ----------------------------------------------------------------
  logic lrst_n;
  assign lrst_n = rst_n & logic_supply_ok;

  // ----------------------------------------------------------------
  // Pin synchronisers in the system domain
  // ----------------------------------------------------------------
  logic [2:0] en_s;
  logic en_f;
  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      en_s <= 3'h0;
      en_f <= 1'b0;
    end else if (clk_en) begin
      en_s <= {en_s[1:0], enable_pin};
      if (en_s[2] == en_s[1]) begin
        en_f <= en_s[1];
      end
    end
  end

  logic [31:0] setup_cnt;
  logic spi_ready;
  always_ff @(posedge clk) begin
    if (!lrst_n || !en_f) begin
      setup_cnt <= 32'h0;
      spi_ready <= 1'b0;
    end else if (clk_en) begin
      if (setup_cnt >= 32'(SETUP_CNT)) begin
        spi_ready <= 1'b1;
      end else begin
        setup_cnt <= setup_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic proto_err, under_flag, over_flag, neg_reset, tsd_flag, tpw_flag;
  logic [N_OUT-1:0] hs_ol, ls_ol;
  logic load_err;
  logic global_error_flag;
  logic [7:0] gsb;
  logic csn_idle;

  // Apply event from the SPI domain
  logic apply_pulse;
  sds_frame_t fr_sys;
  logic clr_gsb, clr_hs, clr_ls, wr_cfg, frame_err;

  always_comb begin
    clr_gsb = 1'b0;
    clr_hs = 1'b0;
    clr_ls = 1'b0;
    wr_cfg = 1'b0;
    frame_err = 1'b0;
    if (apply_pulse) begin
      frame_err = fr_sys.pol_err | ~fr_sys.valid_len;
      if (fr_sys.valid_len) begin
        frame_err = frame_err | ~fr_sys.addr[ADDR_ONE_BIT] | ~fr_sys.addr[ADDR_LAST_ADDRESS_TOKEN_BIT];
        case (fr_sys.addr[ADDR_HI_BIT:ADDR_LO_BIT])
          REG_GLOBAL_STATUS, REG_OPEN_LOAD_HS, REG_OPEN_LOAD_LS, REG_LED_OL_CONFIG: ;
          default: frame_err = 1'b1;
        endcase
      end
      if (!frame_err && fr_sys.addr[ADDR_OP_BIT]) begin
        clr_gsb = fr_sys.addr[ADDR_HI_BIT:ADDR_LO_BIT] == REG_GLOBAL_STATUS;
        clr_hs = fr_sys.addr[ADDR_HI_BIT:ADDR_LO_BIT] == REG_OPEN_LOAD_HS;
        clr_ls = fr_sys.addr[ADDR_HI_BIT:ADDR_LO_BIT] == REG_OPEN_LOAD_LS;
        wr_cfg = fr_sys.addr[ADDR_HI_BIT:ADDR_LO_BIT] == REG_LED_OL_CONFIG;
      end
    end
  end

  // ----------------------------------------------------------------
  // Latched global flags: a set in the clear cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      proto_err <= 1'b0;
    end else if (clk_en) begin
      proto_err <= frame_err | (proto_err & ~clr_gsb);
    end
  end

  // Stages restart on their own; the flag waits for the master
  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      under_flag <= 1'b0;
    end else if (clk_en) begin
      under_flag <= supply_in.under | (under_flag & ~clr_gsb);
    end
  end

  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      over_flag <= 1'b0;
    end else if (clk_en) begin
      over_flag <= supply_in.over | (over_flag & ~clr_gsb);
    end
  end

  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      tsd_flag <= 1'b0;
    end else if (clk_en) begin
      tsd_flag <= supply_in.thermal_shutdown_flag | (tsd_flag & ~clr_gsb);
    end
  end

  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      tpw_flag <= 1'b0;
    end else if (clk_en) begin
      tpw_flag <= supply_in.thermal_warning_flag | (tpw_flag & ~clr_gsb);
    end
  end

  // Power-on marker: zero after any reset until the status byte is cleared
  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      neg_reset <= 1'b0;
    end else if (clk_en && clr_gsb) begin
      neg_reset <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_ol
      always_ff @(posedge clk) begin
        if (!lrst_n) begin
          hs_ol[g] <= 1'b0;
          ls_ol[g] <= 1'b0;
        end else if (clk_en) begin
          // Detector input already filtered; config is not applied, all high sides latch alike
          hs_ol[g] <= (hs_open_load_det[g] & ~freewheel_active[g]) | (hs_ol[g] & ~clr_hs);
          ls_ol[g] <= (ls_open_load_det[g] & ~freewheel_active[g]) | (ls_ol[g] & ~clr_ls);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      led_open_load_config <= LED_OL_CONFIG_RESET;
    end else if (clk_en && wr_cfg) begin
      led_open_load_config <= fr_sys.data;
    end
  end

  always_comb begin
    load_err = |{hs_ol, ls_ol, hs_overcurrent, ls_overcurrent};
    gsb = 8'h00;
    gsb[GSB_PROTO] = proto_err;
    gsb[GSB_LOAD] = load_err;
    gsb[GSB_UNDER] = under_flag;
    gsb[GSB_OVER] = over_flag;
    gsb[GSB_NRESET] = neg_reset;
    gsb[GSB_TSD] = tsd_flag;
    gsb[GSB_TPW] = tpw_flag;
    global_error_flag = proto_err | load_err | under_flag | over_flag | ~neg_reset | tsd_flag | tpw_flag;
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      stages_enable <= 1'b0;
    end else if (clk_en) begin
      stages_enable <= ~supply_in.under & ~supply_in.over;
    end
  end

  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      outputs_hiz <= 1'b1;
    end else if (clk_en) begin
      outputs_hiz <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      global_status_byte_o <= 1'b1;
    end else if (clk_en) begin
      global_status_byte_o <= global_error_flag;
    end
  end

  // Snapshot for the SPI domain; captured in the system domain, held stable
  logic [7:0] gsb_snap, hs_snap, ls_snap;
  logic gef_snap;
  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      gsb_snap <= 8'h00;
      hs_snap <= 8'h00;
      ls_snap <= 8'h00;
      gef_snap <= 1'b1;
    end else if (clk_en && csn_idle) begin
      gsb_snap <= gsb;
      hs_snap <= 8'(hs_ol);
      ls_snap <= 8'(ls_ol);
      gef_snap <= global_error_flag;
    end
  end

  // ----------------------------------------------------------------
  // SPI domain: shift on sclk, framed by csn
  // ----------------------------------------------------------------
  logic [5:0] fall_cnt;
  logic [15:0] rx;
  logic rise_seen;
  logic [3:0] tx_idx;
  logic [7:0] addr_lat;
  always_ff @(negedge sclk or posedge csn) begin
    if (csn) begin
      fall_cnt <= 6'h0;
      rx <= 16'h0;
      addr_lat <= 8'h00;
    end else begin
      rx <= {sdi, rx[15:1]};
      fall_cnt <= fall_cnt + 6'h1;
      // Address byte is whole at the eighth fall; hold it while the reply shifts
      if (fall_cnt == 6'(BYTE_BITS - 1)) begin
        addr_lat <= {sdi, rx[15:9]};
      end
    end
  end

  // Response word: status byte then addressed register
  logic [15:0] tx_word;
  logic [7:0] resp;
  always_comb begin
    case (addr_lat[ADDR_HI_BIT:ADDR_LO_BIT])
      REG_GLOBAL_STATUS: resp = gsb_snap;
      REG_OPEN_LOAD_HS: resp = hs_snap;
      REG_OPEN_LOAD_LS: resp = ls_snap;
      REG_LED_OL_CONFIG: resp = led_open_load_config;
      default: resp = 8'h00;
    endcase
    tx_word = {resp, gsb_snap};
  end

  always_ff @(posedge sclk or posedge csn) begin
    if (csn) begin
      rise_seen <= 1'b0;
      tx_idx <= 4'h0;
    end else begin
      rise_seen <= 1'b1;
      tx_idx <= rise_seen ? tx_idx + 4'h1 : 4'h0;
    end
  end

  // Address is complete only after bit 8; byte 0 shifts GSB first
  always_comb begin
    sdo = rise_seen ? tx_word[tx_idx] : (gef_snap | sdi);
    sdo_oe = ~csn & spi_ready & lrst_n;
  end

  // Polarity check at chip select edges
  logic pol_fall;
  always_ff @(negedge csn) begin
    pol_fall <= sclk;
  end

  // Frame capture at csn rise, toggle to the system domain
  // Clock level at the closing edge is read directly there
  sds_frame_t fr_spi;
  logic fr_tog;
  always_ff @(posedge csn or negedge lrst_n) begin
    if (!lrst_n) begin
      fr_spi <= '0;
      fr_tog <= 1'b0;
    end else begin
      fr_spi.valid_len <= (fall_cnt == 6'h0) ||
        ((fall_cnt >= 6'(FRAME_BITS)) && ((fall_cnt % 6'(BYTE_BITS)) == 6'h0));
      fr_spi.pol_err <= pol_fall | sclk;
      fr_spi.addr <= rx[7:0];
      fr_spi.data <= rx[15:8];
      // A clean zero-clock frame only samples the flag; nothing to apply
      if ((fall_cnt != 6'h0) || pol_fall || sclk) begin
        fr_tog <= ~fr_tog;
      end
    end
  end

  logic [2:0] tog_s;
  logic tog_f;
  logic [2:0] csn_s;
  always_ff @(posedge clk) begin
    if (!lrst_n) begin
      tog_s <= 3'h0;
      tog_f <= 1'b0;
      csn_s <= 3'h7;
      apply_pulse <= 1'b0;
      fr_sys <= '0;
    end else if (clk_en) begin
      tog_s <= {tog_s[1:0], fr_tog};
      csn_s <= {csn_s[1:0], csn};
      // Toggle counts once the last two stages agree, filtering a runt
      if (tog_s[2] == tog_s[1]) begin
        tog_f <= tog_s[2];
      end
      apply_pulse <= (tog_s[2] == tog_s[1]) && (tog_s[2] != tog_f) && spi_ready;
      if ((tog_s[2] == tog_s[1]) && (tog_s[2] != tog_f)) begin
        fr_sys <= fr_spi;
      end
    end
  end
  assign csn_idle = csn_s[2] & csn_s[1];

endmodule

/* File: sim/sds_checker.sv */
// Checker for the SPI status slave, bound to its ports.
// Assumes rst_n resets the clk domain; SETUP_CNT matches the design.
`timescale 1ns/1ps
module sds_checker #(
  parameter int SETUP_CNT = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic logic_supply_ok,
  input wire logic enable_pin,
  input wire logic csn,
  input wire logic sclk,
  input wire logic sdi,
  input wire sds_pkg::sds_supply_t supply_in,
  input wire logic stages_enable,
  input wire logic outputs_hiz,
  input wire logic global_status_byte_o,
  input wire logic sdo,
  input wire logic sdo_oe
);
  import sds_pkg::*;
  int up;
  logic pre;
  logic live;
  // ----------------------------------------
  // Helpers: frame start, setup elapsed
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (csn) begin
      pre <= 1'b1;
    end else if (sclk) begin
      pre <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !logic_supply_ok || !enable_pin) begin
      up <= 0;
    end else if (up < SETUP_CNT + 8) begin
      up <= up + 1;
    end
  end
  assign live = (up >= SETUP_CNT + 8);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_off;
    (supply_in.under || supply_in.over)[*4] |-> !stages_enable;
  endproperty
  a_off: assert property (p_off) else $error("stages on during supply fault");
  property p_back;
    $fell(supply_in.under || supply_in.over) ##1
      (!supply_in.under && !supply_in.over && logic_supply_ok)[*8] |-> stages_enable;
  endproperty
  a_back: assert property (p_back) else $error("stages not restored");
  property p_vdd;
    !logic_supply_ok |=> outputs_hiz && !stages_enable;
  endproperty
  a_vdd: assert property (p_vdd) else $error("outputs driven in logic reset");
  property p_negated_reset_flag;
    $rose(rst_n && logic_supply_ok) |-> global_status_byte_o;
  endproperty
  a_negated_reset_flag: assert property (p_negated_reset_flag) else $error("error flag low after reset");
  property p_gef;
    !csn && pre && !sclk && live |-> sdo_oe && sdo == (global_status_byte_o | sdi);
  endproperty
  a_gef: assert property (p_gef) else $error("frame start output wrong");
  property p_rel;
    csn[*2] |-> !sdo_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("output not released");
  property p_drv;
    !csn && !pre && live |-> sdo_oe;
  endproperty
  a_drv: assert property (p_drv) else $error("output not driven in frame");
  property p_hold;
    (!csn)[*2] |-> $stable(global_status_byte_o);
  endproperty
  a_hold: assert property (p_hold) else $error("flag moved inside frame");
  property p_flag;
    (supply_in.under || supply_in.over || supply_in.thermal_warning_flag)[*3] |-> ##[0:4] global_status_byte_o;
  endproperty
  a_flag: assert property (p_flag) else $error("fault not on error flag");
  c_frame: cover property ($fell(csn));
  c_under: cover property (supply_in.under);
  c_vdd: cover property (!logic_supply_ok);
endmodule
bind sds_spi_slave sds_checker #(.SETUP_CNT(SETUP_CNT)) u_chk (.clk, .rst_n, .logic_supply_ok,
  .enable_pin, .csn, .sclk, .sdi, .supply_in, .stages_enable, .outputs_hiz,
  .global_status_byte_o, .sdo, .sdo_oe);

/* File: sim/sds_spi_master.sv */
// Microcontroller model driving SPI frames, LSB first, 12 ns link clock.
// Assumes the bench calls xfer; sclk stands low between frames.
`timescale 1ns/1ps
module sds_spi_master (
  output logic csn,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    csn = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // ----------------------------------------
  // Frame transfer
  // ----------------------------------------
  task automatic xfer(input int n, input logic [15:0] w, input bit pol,
                      output logic [15:0] r, output logic g);
    r = 16'h0000;
    sdi = 1'b0;
    #5 csn = 1'b0;
    #6 g = sdo;
    for (int i = 0; i < n; i++) begin
      #6 sclk = 1'b1;
      sdi = w[i % 16];
      #6 sclk = 1'b0;
      if (i < 16) begin
        r[i] = sdo;
      end
    end
    // Polarity fault: clock left high across the closing edge only
    #6 sclk = pol;
    #6 csn = 1'b1;
    #6 sclk = 1'b0;
    // Line no longer meaningful, so flip it
    sdi = ~sdi;
  endtask
endmodule

/* File: sim/spi_diag_status_slave_tb_top.sv */
// Bench for the SPI status slave, compared with a small status model.
// Assumes the master model owns the SPI pins; setup shortened to 200.
`timescale 1ns/1ps
module spi_diag_status_slave_tb_top;
  import sds_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ok = 1'b1, en = 1'b0, g;
  sds_supply_t sup = '0;
  logic [7:0] hol = '0, lol = '0, hoc = '0, loc = '0, fw = '0, led, d, exp_st;
  logic stg, hiz, global_error_flag, sdo, sdo_oe, csn, sclk, sdi;
  logic [15:0] r;
  int errors = 0, samples_checked = 0, k, j;
  int nc[7] = '{8, 15, 20, 16, 16, 16, 16};
  initial forever #2 clk = ~clk;
  sds_spi_slave #(.N_OUT(8), .SETUP_CNT(200)) uut (.clk, .rst_n, .clk_en(1'b1),
    .logic_supply_ok(ok), .enable_pin(en), .csn, .sclk, .sdi, .supply_in(sup),
    .hs_open_load_det(hol), .ls_open_load_det(lol), .hs_overcurrent(hoc),
    .ls_overcurrent(loc), .freewheel_active(fw), .stages_enable(stg),
    .outputs_hiz(hiz), .led_open_load_config(led), .global_status_byte_o(global_error_flag),
    .sdo, .sdo_oe);
  // Released line reads inverted, so a missing drive shows up
  sds_spi_master mst (.csn, .sclk, .sdi, .sdo(sdo_oe ? sdo : ~sdo));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    @(negedge clk);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic fr(input int n, input logic op, input logic [4:0] a, input logic [7:0] dd,
                    input bit pol, input logic [1:0] tl);
    mst.xfer(n, {dd, op, a, tl}, pol, r, g);
    cyc(10);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] dd);
    fr(16, 1'b0, a, 8'h00, 0, 2'b11);
    chk(g, exp_st != 8'h08);
    chk(r, {dd, exp_st});
  endtask
  task automatic clr(input logic [4:0] a);
    fr(16, 1'b1, a, 8'hff, 0, 2'b11);
    exp_st = 8'h08;
  endtask
  initial begin
    cyc(100000);
    errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'hd35731f9));
    cyc(20);
    rst_n <= 1'b1;
    cyc(2);
    chk(global_error_flag, 1'b1);
    en <= 1'b1;
    d = 8'($urandom);
    fr(16, 1'b1, 5'h03, d, 0, 2'b11);
    chk(led, 8'h00);
    cyc(200);
    exp_st = 8'h00;
    rd(5'h00, exp_st);
    clr(5'h00);
    rd(5'h00, exp_st);
    fr(0, 1'b0, 5'h00, 8'h00, 0, 2'b11);
    chk(g, 1'b0);
    fr(16, 1'b1, 5'h03, d, 0, 2'b11);
    chk(led, d);
    rd(5'h03, d);
    for (int i = 0; i < 7; i++) begin
      fr(nc[i], 1'b1, i == 3 ? 5'h1f : 5'h03, ~d, i == 6,
         i == 4 ? 2'b10 : i == 5 ? 2'b01 : 2'b11);
      chk(led, d);
      exp_st = 8'h88;
      rd(5'h00, exp_st);
      clr(5'h00);
    end
    k = $urandom % 8;
    j = (k + 1) % 8;
    hol[k] <= 1'b1;
    lol <= 8'(1 << k) | 8'(1 << j);
    fw[j] <= 1'b1;
    cyc(10);
    chk(stg, 1'b1);
    {hol, lol, fw} <= '0;
    exp_st = 8'h48;
    rd(5'h01, 8'(1 << k));
    rd(5'h02, 8'(1 << k));
    clr(5'h01);
    clr(5'h02);
    clr(5'h00);
    rd(5'h02, 8'h00);
    for (int i = 0; i < 3; i++) begin
      sup <= sds_supply_t'(i == 2 ? 4'h1 : 4'h8 >> i);
      cyc(10);
      chk(stg, i == 2);
      sup <= '0;
      cyc(12);
      chk(stg, 1'b1);
      exp_st = i == 2 ? 8'h0a : 8'h08 | (8'h20 >> i);
      rd(5'h00, exp_st);
      clr(5'h00);
    end
    ok <= 1'b0;
    cyc(5);
    chk(hiz, 1'b1);
    ok <= 1'b1;
    cyc(2);
    chk({led, 7'h00, global_error_flag}, 16'h0001);
    cyc(210);
    hoc[k] <= 1'b1;
    loc[j] <= 1'b1;
    cyc(10);
    exp_st = 8'h40;
    rd(5'h00, exp_st);
    report_and_stop;
  end
endmodule
